/* File: hdl/fcpm_top.v */
`include "fcpm_regs.vh"
`default_nettype none
module fcpm_top #(
   parameter WIDTH = 16,
   parameter DIV = `FCPM_SLOW_DIV
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output reg wb_err_o,
   // Pins
   output reg [3:0] pwm_pin_o
);
   reg [3:0] run_ff, div_sel_ff, en_ff, align_ff, pol_ff;
   reg burst_ff, shot2_ff, shot3_ff;
   reg [5:0] div_cnt_ff;
   wire [3:0] stop;
   wire [3:0] raw;
   wire [WIDTH*4-1:0] cnt_bus, per_bus, wid_bus;

   // Clock divider for the slow count pulse
   wire slow_tick = (div_cnt_ff == DIV[5:0] - 6'h01);
   always @(posedge clk_i) begin
      if (rst_i)
         div_cnt_ff <= 6'h00;
      else if (slow_tick)
         div_cnt_ff <= 6'h00;
      else
         div_cnt_ff <= div_cnt_ff + 6'h01;
   end

   // Bus decode; one-cycle ack, dropped the cycle after
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   wire wr = req && wb_we_i && wb_sel_i[0] && wb_sel_i[1];
   wire [7:0] a = wb_adr_i;
   wire hit_ctl = (a == `FCPM_OFS_CON0) || (a == `FCPM_OFS_CON1) || (a == `FCPM_OFS_POL);
   wire hit_ch = (a[1:0] == 2'b00) && (a[3:2] != 2'b00 || 1'b1) &&
      ((a[7:4] == 4'h1) || (a[7:4] == 4'h2) || (a[7:4] == 4'h3)) && (a[3:2] == a[3:2]);
   wire hit = hit_ctl || hit_ch;
   wire [1:0] ch = a[3:2];
   wire [WIDTH-1:0] wd = wb_dat_i[WIDTH-1:0];
   wire con0_wr = wr && (a == `FCPM_OFS_CON0);

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_ch
         wire cw = wr && (a[7:4] == 4'h1) && (ch == g);
         wire pw = wr && (a[7:4] == 4'h2) && (ch == g);
         wire ww = wr && (a[7:4] == 4'h3) && (ch == g);
         wire tk = div_sel_ff[g] ? slow_tick : 1'b1;
         wire sh = (g == 2) ? shot2_ff : (g == 3) ? shot3_ff : 1'b0;
         fcpm_channel #(
            .WIDTH(WIDTH),
            .SHOT_OK((g >= 2) ? 1 : 0)
         ) u_ch (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .run_i(run_ff[g]),
            .tick_i(tk),
            .align_i(align_ff[g]),
            .shot_i(sh),
            .cnt_we_i(cw),
            .per_we_i(pw),
            .wid_we_i(ww),
            .wdata_i(wd),
            .stop_o(stop[g]),
            .cnt_o(cnt_bus[g*WIDTH +: WIDTH]),
            .per_o(per_bus[g*WIDTH +: WIDTH]),
            .wid_o(wid_bus[g*WIDTH +: WIDTH]),
            .pwm_o(raw[g])
         );
      end
   endgenerate

   // Control registers; hardware stop wins over a software write
   always @(posedge clk_i) begin
      if (rst_i) begin
         run_ff <= 4'h0;
         div_sel_ff <= 4'h0;
         en_ff <= 4'h0;
         align_ff <= 4'h0;
         pol_ff <= 4'h0;
         burst_ff <= 1'b0;
         shot2_ff <= 1'b0;
         shot3_ff <= 1'b0;
      end else begin
         if (con0_wr) begin
            run_ff <= wd[`FCPM_CON0_RUN_LSB +: 4] & ~stop;
            div_sel_ff <= wd[`FCPM_CON0_DIV_LSB +: 4];
         end else begin
            run_ff <= run_ff & ~stop;
         end
         if (wr && a == `FCPM_OFS_CON1) begin
            en_ff <= wd[`FCPM_CON1_EN_LSB +: 4];
            align_ff <= wd[`FCPM_CON1_ALIGN_LSB +: 4];
            burst_ff <= wd[`FCPM_CON1_BURST_BIT];
            shot2_ff <= wd[`FCPM_CON1_SHOT2_BIT];
            shot3_ff <= wd[`FCPM_CON1_SHOT3_BIT];
         end
         if (wr && a == `FCPM_OFS_POL)
            pol_ff <= wd[3:0];
      end
   end

   // Pin stage: AND, then polarity, then register
   wire out0 = burst_ff ? (raw[0] & raw[1]) : raw[0];
   wire [3:0] gated = {raw[3:1], out0} & en_ff;
   always @(posedge clk_i) begin
      if (rst_i)
         pwm_pin_o <= 4'h0;
      else
         pwm_pin_o <= gated ^ pol_ff;
   end

   // Read mux and acknowledge
   reg [15:0] rd;
   always @* begin
      rd = 16'h0000;
      case (a[7:4])
         4'h0: begin
            if (a == `FCPM_OFS_CON0)
               rd = {8'h00, div_sel_ff, run_ff};
            else if (a == `FCPM_OFS_CON1)
               rd = {shot3_ff, shot2_ff, 1'b0, burst_ff, 4'h0, align_ff, en_ff};
            else if (a == `FCPM_OFS_POL)
               rd = {12'h000, pol_ff};
         end
         4'h1: rd = cnt_bus[ch*WIDTH +: 16];
         4'h2: rd = per_bus[ch*WIDTH +: 16];
         4'h3: rd = wid_bus[ch*WIDTH +: 16];
         default: rd = 16'h0000;
      endcase
   end
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req && hit;
         wb_err_o <= req && !hit;
         wb_dat_o <= {16'h0000, rd};
      end
   end
endmodule // fcpm_top
`default_nettype wire

/* File: hdl/fcpm_regs.vh */
`ifndef FCPM_REGS_VH
`define FCPM_REGS_VH
// Register byte offsets
`define FCPM_OFS_CON0 8'h00
`define FCPM_OFS_CON1 8'h04
`define FCPM_OFS_POL 8'h08
`define FCPM_OFS_CNT0 8'h10
`define FCPM_OFS_PER0 8'h20
`define FCPM_OFS_WID0 8'h30
// Control fields
`define FCPM_CON0_RUN_LSB 0
`define FCPM_CON0_DIV_LSB 4
`define FCPM_CON1_EN_LSB 0
`define FCPM_CON1_ALIGN_LSB 4
`define FCPM_CON1_BURST_BIT 12
`define FCPM_CON1_SHOT2_BIT 14
`define FCPM_CON1_SHOT3_BIT 15
// Reset values
`define FCPM_RST_WORD 16'h0000
// Timing
`define FCPM_SLOW_DIV 64
`endif

/* File: hdl/fcpm_channel.v */
`include "fcpm_regs.vh"
`default_nettype none
module fcpm_channel #(
   parameter WIDTH = 16,
   parameter SHOT_OK = 0
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Control
   input wire run_i,
   input wire tick_i,
   input wire align_i,
   input wire shot_i,
   // Software writes
   input wire cnt_we_i,
   input wire per_we_i,
   input wire wid_we_i,
   input wire [WIDTH-1:0] wdata_i,
   // Status
   output wire stop_o,
   output wire [WIDTH-1:0] cnt_o,
   output wire [WIDTH-1:0] per_o,
   output wire [WIDTH-1:0] wid_o,
   output wire pwm_o
);
   reg [WIDTH-1:0] cnt_ff, per_ff, wid_ff, per_sh_ff, wid_sh_ff;
   reg down_ff, out_ff;
   wire shot = shot_i && (SHOT_OK != 0);
   wire at_top = (cnt_ff == per_sh_ff);
   wire at_bot = (cnt_ff == {WIDTH{1'b0}});
   wire step = run_i && tick_i;
   reg [WIDTH-1:0] nxt_cnt;
   reg nxt_down;
   reg cyc_start;
   always @* begin
      nxt_cnt = cnt_ff;
      nxt_down = down_ff;
      cyc_start = 1'b0;
      if (align_i && !shot) begin
         // Counter holds one pulse at each turn, giving 2 x (period + 1)
         if (!down_ff) begin
            if (at_top) begin
               nxt_down = 1'b1;
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end else if (at_bot) begin
            nxt_down = 1'b0;
            cyc_start = 1'b1;
         end else begin
            nxt_cnt = cnt_ff - 1'b1;
         end
      end else begin
         nxt_down = 1'b0;
         if (at_top) begin
            nxt_cnt = {WIDTH{1'b0}};
            cyc_start = 1'b1;
         end else begin
            nxt_cnt = cnt_ff + 1'b1;
         end
      end
   end
   // Single shot ends on the wrap; writing the counter to the period ends it early
   assign stop_o = step && shot && at_top;
   wire load_sh = (step && cyc_start) || !run_i;
   // Comparator on the next count value, so the pin follows the counter
   wire ge_w = (nxt_cnt >= wid_sh_ff);
   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt_ff <= `FCPM_RST_WORD;
         per_ff <= `FCPM_RST_WORD;
         wid_ff <= `FCPM_RST_WORD;
         per_sh_ff <= `FCPM_RST_WORD;
         wid_sh_ff <= `FCPM_RST_WORD;
         down_ff <= 1'b0;
         out_ff <= 1'b0;
      end else begin
         if (per_we_i)
            per_ff <= wdata_i;
         if (wid_we_i)
            wid_ff <= wdata_i;
         if (load_sh) begin
            per_sh_ff <= per_we_i ? wdata_i : per_ff;
            wid_sh_ff <= wid_we_i ? wdata_i : wid_ff;
         end
         if (cnt_we_i) begin
            cnt_ff <= wdata_i;
         end else if (step) begin
            cnt_ff <= nxt_cnt;
            down_ff <= nxt_down;
            if (align_i && !shot) begin
               // Rises only counting up; goes low below the width counting either way
               if (!nxt_down && ge_w)
                  out_ff <= 1'b1;
               else if (nxt_down && !ge_w)
                  out_ff <= 1'b0;
               else if (!nxt_down && !ge_w)
                  out_ff <= 1'b0;
            end else begin
               out_ff <= ge_w;
            end
         end
      end
   end
   assign cnt_o = cnt_ff;
   assign per_o = per_ff;
   assign wid_o = wid_ff;
   assign pwm_o = out_ff;
endmodule // fcpm_channel
`default_nettype wire

/* File: tb/fcpm_top_asserts.sv */
`default_nettype none
module fcpm_top_asserts (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   // Pins
   input wire logic [3:0] pwm_pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   wire logic mapped = wb_adr_i[1:0] == 2'h0 && (wb_adr_i[7:4] == 4'h1 ||
      wb_adr_i[7:4] == 4'h2 || wb_adr_i[7:4] == 4'h3 || wb_adr_i < 8'h0c);
   a_answer_in_one: assert property (req |=> wb_ack_o || wb_err_o)
      else $error("request not answered in one cycle");
   a_mapped_acks: assert property (req && mapped |=> wb_ack_o)
      else $error("mapped access not acked");
   a_err_unmapped: assert property (wb_err_o |-> !$past(mapped))
      else $error("error on a mapped address");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_err_pulse: assert property (wb_err_o |=> !wb_err_o)
      else $error("err longer than one cycle");
   a_ack_err_excl: assert property (!(wb_ack_o && wb_err_o))
      else $error("ack and err together");
   a_ack_caused: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   a_pins_reset: assert property (disable iff (1'b0) rst_i |=> pwm_pin_o == 4'h0)
      else $error("pins not low after reset");
endmodule // fcpm_top_asserts
bind fcpm_top fcpm_top_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .wb_err_o(wb_err_o), .pwm_pin_o(pwm_pin_o));
`default_nettype wire

/* File: tb/fcpm_pin_load.sv */
`default_nettype none
module fcpm_pin_load (
   input wire logic clk_i,
   input wire logic clr_i,
   input wire logic [3:0] pin_i,
   output var logic [3:0][15:0] rises_o,
   output var logic [3:0][15:0] highs_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] prev_ff = 4'h0;
   // Pins are sampled like a port input, one level per clock
   always @(posedge clk_i) begin
      prev_ff <= pin_i;
      for (int i = 0; i < 4; i++) begin
         rises_o[i] <= clr_i ? 16'h0000 : rises_o[i] + 16'(pin_i[i] & ~prev_ff[i]);
         highs_o[i] <= clr_i ? 16'h0000 : highs_o[i] + 16'(pin_i[i]);
      end
   end
endmodule // fcpm_pin_load
`default_nettype wire

/* File: tb/fcpm_top_tb.sv */
`default_nettype none
module fcpm_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, clr = 0, e;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0, rd, seed = 32'h42594b36;
   wire logic [31:0] dat_o;
   wire logic ack, err;
   wire logic [3:0] pin;
   wire logic [3:0][15:0] rises, highs;
   int failures = 0, n_tests = 0, p, w, ch, al, per;
   // Small divider; none of these tests selects the slow tick
   fcpm_top #(.WIDTH(16), .DIV(4)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err), .pwm_pin_o(pin));
   fcpm_pin_load u_pins (.clk_i(clk_i), .clr_i(clr), .pin_i(pin), .rises_o(rises),
      .highs_o(highs));
   initial forever #2 clk_i = ~clk_i;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int hi_edge(int p, int w);
      if (w == 0) return p + 1;
      if (w > p) return 0;
      return p + 1 - w;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w_, input int a, input int d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w_;
      adr <= 8'(a);
      dat <= 32'(d);
      sel <= 4'hf;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1 && err !== 1'b1);
      rd = dat_o;
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic meas(input int len);
      @(posedge clk_i);
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
      repeat (len) @(posedge clk_i);
      #1;
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #200000;
      failures++;
      test_done();
   end
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, 8'h04, 0);
      chk(rd, 0);
      wb(0, 8'h0c, 0);
      chk(32'(e), 1);
      for (int i = 0; i < 8; i++) begin
         ch = i % 4;
         al = i / 4;
         p = 2 + int'(rnd() % 8);
         w = (i == 1) ? 0 : (i == 2 || i == 7) ? p + 1 : 1 + int'(rnd() % p);
         wb(1, 8'h00, 0);
         wb(1, 8'h20 + 4 * ch, p);
         wb(1, 8'h30 + 4 * ch, w);
         wb(1, 8'h10 + 4 * ch, 0);
         wb(0, 8'h20 + 4 * ch, 0);
         chk(rd, p);
         wb(1, 8'h04, (al << (4 + ch)) | (1 << ch));
         wb(1, 8'h00, 1 << ch);
         per = (al + 1) * (p + 1);
         repeat (2 * per) @(posedge clk_i);
         meas(8 * per);
         chk(rises[ch], (w == 0 || w > p) ? 0 : 8);
         if (al == 0) chk(highs[ch], 8 * hi_edge(p, w));
      end
      // Burst: channel 0 always high, channel 1 always low
      wb(1, 8'h00, 0);
      wb(1, 8'h20, 3);
      wb(1, 8'h30, 0);
      wb(1, 8'h24, 3);
      wb(1, 8'h34, 5);
      // Counters left over from earlier runs may sit above the new period
      wb(1, 8'h10, 0);
      wb(1, 8'h14, 0);
      wb(1, 8'h04, 32'h1023);
      wb(1, 8'h00, 3);
      meas(32);
      chk(highs[0], 0);
      wb(1, 8'h08, 1);
      meas(32);
      chk(highs[0], 32);
      wb(1, 8'h08, 0);
      // Single shot on channel 2, fired twice, then aborted by writing the counter to the period
      wb(1, 8'h00, 0);
      wb(1, 8'h28, 7);
      wb(1, 8'h38, 4);
      wb(1, 8'h18, 0);
      wb(1, 8'h04, 32'h4004);
      for (int k = 0; k < 2; k++) begin
         wb(1, 8'h00, 4);
         meas(60);
         chk(rises[2], 1);
         chk(highs[2], 4);
         wb(0, 8'h00, 0);
         chk(rd[2], 0);
      end
      wb(1, 8'h00, 4);
      wb(1, 8'h18, 7);
      repeat (4) @(posedge clk_i);
      wb(0, 8'h00, 0);
      chk(rd[2], 0);
      test_done();
   end
endmodule // fcpm_top_tb
`default_nettype wire
